/* File: verilog/lsi_defines.svh */
// register offsets, field positions, reset values and timing counts of the indicator block
`ifndef LSI_DEFINES_SVH
`define LSI_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define LSI_ADDR_W          12
`define LSI_OFS_CTRL        12'h000
`define LSI_OFS_PROGEN      12'h004

// ****************************************************************
// indicator control fields
// ****************************************************************
`define LSI_BIT_COMBINED    15
`define LSI_BIT_POLARITY    14
`define LSI_BIT_DISABLE     13
`define LSI_BIT_SPEED       12
`define LSI_BIT_WAKE        9
`define LSI_BIT_FDLINK      8
`define LSI_BIT_STRETCH     7
`define LSI_BIT_LINK        6
`define LSI_BIT_RXMATCH     5
`define LSI_BIT_TXACT       4
`define LSI_BIT_PROGEN      0

// ****************************************************************
// reset values and masks
// ****************************************************************
`define LSI_CTRL_RESET      32'h0000_0080
`define LSI_CTRL_WMASK      32'h0000_73F0
`define LSI_PROGEN_RESET    1'b0

// ****************************************************************
// timing
// ****************************************************************
`define LSI_CLK_KHZ         25000
`define LSI_STRETCH_MS      20
`define LSI_STRETCH_CYCLES  (`LSI_STRETCH_MS * `LSI_CLK_KHZ)

`endif

/* File: verilog/lsi_pkg.sv */
// types shared by the indicator block
package lsi_pkg;

    // ****************************************************************
    // network event sources
    // ****************************************************************
    typedef struct packed {
        logic speed100;
        logic wakeMode;
        logic wakeDetect;
        logic linkPass;
        logic fullDuplex;
        logic rxMatch;
        logic txActive;
    } lsi_events_s;

    // ****************************************************************
    // led pin drive
    // ****************************************************************
    typedef struct packed {
        logic level;
        logic drvN;
    } lsi_pin_s;

    typedef logic [31:0] lsi_word_t;

endpackage : lsi_pkg

/* File: verilog/lsi_stretch.sv */
// retriggerable pulse stretcher for the indicator pin
`timescale 1ns/1ps
module lsi_stretch #(
    parameter int STRETCH_CYCLES = 500000,
    parameter int CNT_W          = $clog2(STRETCH_CYCLES + 1)
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    // control
    input  wire logic trigger,
    input  wire logic enable,
    // status
    output logic      active
);
    import lsi_pkg::*;

    logic [CNT_W-1:0] cntQ;
    logic [CNT_W-1:0] cntD;

    // ****************************************************************
    // counter
    // ****************************************************************
    always_comb begin
        cntD = cntQ;
        if (!enable) begin
            cntD = '0;                                   // [RULE_12]
        end else if (trigger) begin
            cntD = CNT_W'(STRETCH_CYCLES);               // [RULE_20]
        end else if (cntQ != '0) begin
            cntD = cntQ - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cntQ <= '0;
        end else if (clkEn) begin
            cntQ <= cntD;
        end
    end

    assign active = enable && (cntQ != '0);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_STRETCH_LOAD: assert property ((clkEn && enable && trigger) |=> cntQ == CNT_W'(STRETCH_CYCLES)) // [RULE_20]
        else $error("stretch counter not reloaded on trigger");
    AST_STRETCH_OFF: assert property ((clkEn && !enable) |=> (cntQ == '0) && !active) // [RULE_12]
        else $error("stretch active while disabled");
    AST_STRETCH_COUNT: assert property ((clkEn && enable && !trigger && cntQ != '0) |=> cntQ == $past(cntQ) - 1) // [RULE_20]
        else $error("stretch counter did not count down");

endmodule : lsi_stretch

/* File: verilog/lsi_top.sv */
// led status indicator: apb register slave, event combiner, stretcher and pin driver
//
// What this block does
// RULE_01: combined state is the OR of all enabled event sources.
// RULE_02: polarity 0: pull pin low when lit, release it otherwise.
// RULE_03: polarity 1: drive pin high when lit, low otherwise.
// RULE_04: readable combined bit reports true as 1 regardless of polarity.
// RULE_05: hard reset clears polarity; soft reset and stop leave it.
// RULE_06: output disable at bit 13 keeps the pin released.
// RULE_07: hard reset clears output disable; soft reset and stop leave it.
// RULE_08: speed enable at bit 12 lights on 100 Mbps operation.
// RULE_09: bits 11 to 10 read zero and are written as zero.
// RULE_10: wake enable at bit 9 lights on wake mode with wake frame.
// RULE_11: full-duplex link enable at bit 8 lights on link pass and full duplex.
// RULE_12: stretch enable at bit 7 lengthens pin lit time, never the status bit.
// RULE_13: hard reset sets stretch enable to 1.
// RULE_14: link enable at bit 6 lights while link passes.
// RULE_15: matched receive enable at bit 5 lights on address-matched receive.
// RULE_16: transmit enable at bit 4 lights on transmit activity.
// RULE_17: hard reset clears all event enables; soft reset and stop leave them.
// RULE_18: control register writes are ignored unless program enable is 1.
// RULE_19: combined status bit is read only.
// RULE_20: stretch is a retriggerable fixed-length counter restarted on each rise.
// RULE_21: combined state and pin are registered, settling one cycle after events.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "lsi_defines.svh"
module lsi_top #(
    parameter int STRETCH_CYCLES = `LSI_STRETCH_CYCLES
) (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      clkEn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`LSI_ADDR_W-1:0]    paddr,
    input  wire lsi_pkg::lsi_word_t        pwdata,
    output lsi_pkg::lsi_word_t             prdata,
    output logic                           pready,
    output logic                           pslverr,
    // network events
    input  wire lsi_pkg::lsi_events_s      netEvents,
    // led pin
    output lsi_pkg::lsi_pin_s              ledPin
);
    import lsi_pkg::*;

    localparam int NSRC = 6;

    // ****************************************************************
    // declarations
    // ****************************************************************
    lsi_word_t       ctrlQ;
    lsi_word_t       ctrlD;
    logic            progEnQ;
    logic            progEnD;
    lsi_word_t       prdataQ;
    lsi_word_t       prdataD;
    logic            errQ;
    logic            errD;
    logic            rdValidQ;
    logic            rdValidD;
    logic            combinedQ;
    logic            combinedD;
    lsi_pin_s        pinQ;
    lsi_pin_s        pinD;
    logic [NSRC-1:0] srcVec;
    logic [NSRC-1:0] enVec;
    logic [NSRC-1:0] termVec;
    logic            setupPh;
    logic            accessPh;
    logic            wrFire;
    logic            rise;
    logic            stretchOn;
    logic            litD;
    lsi_word_t       ctrlRead;

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic isHit(input logic [`LSI_ADDR_W-1:0] addr, input logic [`LSI_ADDR_W-1:0] ofs);
        isHit = (addr[`LSI_ADDR_W-1:2] == ofs[`LSI_ADDR_W-1:2]);
    endfunction : isHit

    // ****************************************************************
    // apb handshake
    // ****************************************************************
    assign setupPh  = psel && !penable;
    assign accessPh = psel && penable;
    assign pready   = accessPh && rdValidQ && clkEn;
    assign pslverr  = pready && errQ;
    assign wrFire   = pready && pwrite;
    assign prdata   = prdataQ;

    // readback image with the live status bit and reserved bits at zero
    always_comb begin
        ctrlRead = ctrlQ & `LSI_CTRL_WMASK;                          // [RULE_09]
        ctrlRead[`LSI_BIT_COMBINED] = combinedQ;                     // [RULE_04]
    end

    always_comb begin
        prdataD  = prdataQ;
        errD     = errQ;
        rdValidD = rdValidQ;
        // an access whose setup was missed while frozen is loaded here
        if (setupPh || (accessPh && !rdValidQ)) begin
            rdValidD = 1'b1;
            errD     = 1'b0;
            prdataD  = '0;
            if (isHit(paddr, `LSI_OFS_CTRL)) begin
                prdataD = pwrite ? '0 : ctrlRead;
            end else if (isHit(paddr, `LSI_OFS_PROGEN)) begin
                prdataD = pwrite ? '0 : {31'h0000_0000, progEnQ};
            end else begin
                errD = 1'b1;
            end
        end else if (pready) begin
            rdValidD = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdataQ  <= '0;
            errQ     <= 1'b0;
            rdValidQ <= 1'b0;
        end else if (clkEn) begin
            prdataQ  <= prdataD;
            errQ     <= errD;
            rdValidQ <= rdValidD;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_comb begin
        ctrlD   = ctrlQ;
        progEnD = progEnQ;
        if (wrFire && isHit(paddr, `LSI_OFS_CTRL) && progEnQ) begin  // [RULE_18]
            ctrlD = pwdata & `LSI_CTRL_WMASK;                        // [RULE_09] [RULE_19]
        end
        if (wrFire && isHit(paddr, `LSI_OFS_PROGEN)) begin
            progEnD = pwdata[`LSI_BIT_PROGEN];
        end
    end

    // only hard reset touches these; soft reset and stop have no path here
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrlQ   <= `LSI_CTRL_RESET;                              // [RULE_05] [RULE_07] [RULE_13] [RULE_17]
            progEnQ <= `LSI_PROGEN_RESET;
        end else if (clkEn) begin
            ctrlQ   <= ctrlD;
            progEnQ <= progEnD;
        end
    end

    // ****************************************************************
    // event combiner
    // ****************************************************************
    assign srcVec = {netEvents.speed100,                                    // [RULE_08]
                     netEvents.wakeMode && netEvents.wakeDetect,            // [RULE_10]
                     netEvents.linkPass && netEvents.fullDuplex,            // [RULE_11]
                     netEvents.linkPass,                                    // [RULE_14]
                     netEvents.rxMatch,                                     // [RULE_15]
                     netEvents.txActive};                                   // [RULE_16]
    assign enVec  = {ctrlQ[`LSI_BIT_SPEED], ctrlQ[`LSI_BIT_WAKE], ctrlQ[`LSI_BIT_FDLINK],
                     ctrlQ[`LSI_BIT_LINK], ctrlQ[`LSI_BIT_RXMATCH], ctrlQ[`LSI_BIT_TXACT]};

    for (genvar i = 0; i < NSRC; i++) begin : g_term
        assign termVec[i] = srcVec[i] && enVec[i];
    end

    assign combinedD = |termVec;                                     // [RULE_01]
    assign rise      = combinedD && !combinedQ;

    // ****************************************************************
    // pulse stretcher
    // ****************************************************************
    lsi_stretch #(
        .STRETCH_CYCLES (STRETCH_CYCLES)
    ) u_stretch (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .trigger (rise),                                             // [RULE_20]
        .enable  (ctrlQ[`LSI_BIT_STRETCH]),                          // [RULE_12]
        .active  (stretchOn)
    );

    assign litD = combinedD || stretchOn;                            // [RULE_12]

    // ****************************************************************
    // pin driver
    // ****************************************************************
    always_comb begin
        pinD = '{level: 1'b0, drvN: 1'b1};
        if (ctrlQ[`LSI_BIT_DISABLE]) begin
            pinD = '{level: 1'b0, drvN: 1'b1};                       // [RULE_06]
        end else if (ctrlQ[`LSI_BIT_POLARITY]) begin
            pinD = '{level: litD, drvN: 1'b0};                       // [RULE_03]
        end else begin
            pinD = '{level: 1'b0, drvN: !litD};                      // [RULE_02]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            combinedQ <= 1'b0;
            pinQ      <= '{level: 1'b0, drvN: 1'b1};
        end else if (clkEn) begin
            combinedQ <= combinedD;                                  // [RULE_21]
            pinQ      <= pinD;                                       // [RULE_21]
        end
    end

    assign ledPin = pinQ;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_COMBINED_OR: assert property (clkEn |=> combinedQ == $past(|termVec)) // [RULE_01]
        else $error("combined state is not the OR of enabled terms");
    AST_OPEN_DRAIN: assert property ((clkEn && !ctrlQ[`LSI_BIT_POLARITY] && !ctrlQ[`LSI_BIT_DISABLE])
        |=> (pinQ.drvN == !$past(litD)) && !pinQ.level) // [RULE_02]
        else $error("open drain drive wrong");
    AST_TOTEM: assert property ((clkEn && ctrlQ[`LSI_BIT_POLARITY] && !ctrlQ[`LSI_BIT_DISABLE])
        |=> !pinQ.drvN && (pinQ.level == $past(litD))) // [RULE_03]
        else $error("totem pole drive wrong");
    AST_READ_STATUS: assert property ((clkEn && setupPh && !pwrite && isHit(paddr, `LSI_OFS_CTRL))
        |=> prdataQ[`LSI_BIT_COMBINED] == $past(combinedQ)) // [RULE_04]
        else $error("status bit readback wrong");
    AST_DISABLE: assert property ((clkEn && ctrlQ[`LSI_BIT_DISABLE]) |=> pinQ.drvN) // [RULE_06]
        else $error("pin driven while disabled");
    AST_SPEED: assert property ((clkEn && ctrlQ[`LSI_BIT_SPEED] && netEvents.speed100) |=> combinedQ) // [RULE_08]
        else $error("speed term missing");
    AST_RESERVED: assert property (prdataQ[11:10] == 2'b00 && ctrlQ[11:10] == 2'b00) // [RULE_09]
        else $error("reserved bits not zero");
    AST_FDLINK: assert property ((clkEn && enVec == 6'b00_1000 && !(netEvents.linkPass && netEvents.fullDuplex))
        |=> !combinedQ) // [RULE_11]
        else $error("full duplex link term lit without cause");
    AST_WRITE_LOCKED: assert property ((wrFire && isHit(paddr, `LSI_OFS_CTRL) && !progEnQ) |=> $stable(ctrlQ)) // [RULE_18]
        else $error("write accepted while programming locked");
    AST_WRITE_TAKEN: assert property ((wrFire && isHit(paddr, `LSI_OFS_CTRL) && progEnQ)
        |=> ctrlQ == ($past(pwdata) & `LSI_CTRL_WMASK)) // [RULE_19]
        else $error("accepted write not stored as masked");
    AST_STRETCH_PIN: assert property ((clkEn && rise && ctrlQ[`LSI_BIT_STRETCH] && ctrlQ[`LSI_BIT_POLARITY]
        && !ctrlQ[`LSI_BIT_DISABLE]) ##1 (clkEn && $stable(ctrlQ)) |=> pinQ.level) // [RULE_12]
        else $error("pin not stretched after rise");

    // ****************************************************************
    // checks: event terms, reset values, register hold, stretch, pin disable and apb responses
    // ****************************************************************
    AST_HARD_RESET: assert property ($fell(rst) |-> // [RULE_05] [RULE_07] [RULE_13] [RULE_17]
        (ctrlQ == `LSI_CTRL_RESET) && !progEnQ)
        else $error("registers not at reset values");
    AST_CTRL_HOLD: assert property (!(wrFire && progEnQ && isHit(paddr, `LSI_OFS_CTRL)) // [RULE_17]
        |=> $stable(ctrlQ))
        else $error("control changed without accepted write");
    AST_WAKE: assert property ((clkEn && ctrlQ[`LSI_BIT_WAKE] && netEvents.wakeMode // [RULE_10]
        && netEvents.wakeDetect) |=> combinedQ)
        else $error("wake term missing");
    AST_FDLINK_ON: assert property ((clkEn && ctrlQ[`LSI_BIT_FDLINK] && netEvents.linkPass // [RULE_11]
        && netEvents.fullDuplex) |=> combinedQ)
        else $error("full duplex link term missing");
    AST_LINK: assert property ((clkEn && ctrlQ[`LSI_BIT_LINK] && netEvents.linkPass) // [RULE_14]
        |=> combinedQ)
        else $error("link term missing");
    AST_RXMATCH: assert property ((clkEn && ctrlQ[`LSI_BIT_RXMATCH] && netEvents.rxMatch) // [RULE_15]
        |=> combinedQ)
        else $error("matched receive term missing");
    AST_TXACT: assert property ((clkEn && ctrlQ[`LSI_BIT_TXACT] && netEvents.txActive) // [RULE_16]
        |=> combinedQ)
        else $error("transmit term missing");
    AST_STATUS_RAW: assert property ((clkEn && stretchOn && !combinedD) |=> !combinedQ) // [RULE_12]
        else $error("status bit stretched");
    AST_STRETCH_GATED: assert property ((clkEn && !ctrlQ[`LSI_BIT_STRETCH] && ctrlQ[`LSI_BIT_POLARITY] // [RULE_12]
        && !ctrlQ[`LSI_BIT_DISABLE] && !combinedD) |=> !pinQ.level)
        else $error("pin stretched while stretch off");
    AST_STRETCH_HOLD: assert property ((clkEn && stretchOn && ctrlQ[`LSI_BIT_POLARITY] // [RULE_20]
        && !ctrlQ[`LSI_BIT_DISABLE]) |=> pinQ.level)
        else $error("pin dark while stretch runs");
    AST_DISABLE_LEVEL: assert property ((clkEn && ctrlQ[`LSI_BIT_DISABLE]) |=> !pinQ.level) // [RULE_06]
        else $error("disabled pin level not low");
    AST_PROGEN_WRITE: assert property ((wrFire && isHit(paddr, `LSI_OFS_PROGEN)) // [RULE_18]
        |=> progEnQ == $past(pwdata[`LSI_BIT_PROGEN]))
        else $error("program enable not stored");
    AST_UNMAPPED: assert property ((clkEn && setupPh && !isHit(paddr, `LSI_OFS_CTRL)
        && !isHit(paddr, `LSI_OFS_PROGEN)) |=> errQ && (prdataQ == '0))
        else $error("unmapped access not flagged");
    AST_NO_WAIT: assert property ((clkEn && setupPh) ##1 (clkEn && accessPh) |-> pready)
        else $error("access phase not answered at once");

    COV_WRITE_OK: cover property (wrFire && isHit(paddr, `LSI_OFS_CTRL) && progEnQ);
    COV_STRETCH: cover property (clkEn && rise && ctrlQ[`LSI_BIT_STRETCH]);
    COV_TOTEM_LIT: cover property (!pinQ.drvN && pinQ.level);
    COV_UNMAPPED: cover property (pslverr);
    COV_OPEN_DRAIN_LIT: cover property (!pinQ.drvN && !pinQ.level);

endmodule : lsi_top

/* File: test/lsi_led_model.sv */
// external indicator lamp with pull-up on its pad
`timescale 1ns/1ps
module lsi_led_model (
    // pin from the block
    input  wire lsi_pkg::lsi_pin_s ledPin,
    // resolved pad level
    output logic                   padLevel
);
    import lsi_pkg::*;
    // ****************************************************************
    // pad resolution
    // ****************************************************************
    // released pad floats high through the pull-up
    assign padLevel = ledPin.drvN ? 1'b1 : ledPin.level;
endmodule : lsi_led_model

/* File: test/lsi_top_test.sv */
// self-checking bench of the indicator block
`timescale 1ns/1ps
`include "lsi_defines.svh"
module lsi_top_test;
    import lsi_pkg::*;
    localparam int SC = 16;
    typedef struct packed { logic isRd; logic err; lsi_word_t data; } lsi_exp_s;
    logic                       sys_clk;
    logic                       rst;
    logic                       clkEn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic                       pinReq;
    logic                       padLevel;
    logic                       pready;
    logic                       pslverr;
    logic [`LSI_ADDR_W-1:0]     paddr;
    lsi_word_t                  pwdata;
    lsi_word_t                  prdata;
    lsi_word_t                  cv;
    lsi_events_s                netEvents;
    lsi_pin_s                   ledPin;
    lsi_exp_s                   curE;
    lsi_exp_s                   expQ[$];
    logic                       pinQ[$];
    logic [6:0]                 evr;
    logic [31:0]                seed;
    int                         errors;
    int                         cmp_count;
    int                         i;
    int                         bitTab[6] = '{12, 9, 8, 6, 5, 4};
    logic [6:0]                 onTab[6]  = '{7'h40, 7'h30, 7'h0C, 7'h08, 7'h02, 7'h01};
    logic [6:0]                 offTab[6] = '{7'h3F, 7'h6F, 7'h7B, 7'h77, 7'h7D, 7'h7E};

    lsi_top #(.STRETCH_CYCLES(SC)) u_lsi_top (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .netEvents(netEvents), .ledPin(ledPin));
    lsi_led_model u_lsi_led_model (.ledPin(ledPin), .padLevel(padLevel));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic comb(lsi_word_t c, logic [6:0] e);
        return (c[12] & e[6]) | (c[9] & e[5] & e[4]) | (c[8] & e[3] & e[2]) | (c[6] & e[3]) | (c[5] & e[1])
            | (c[4] & e[0]);
    endfunction : comb

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cmp_word(input lsi_word_t got, input lsi_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_pin(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_pin

    // ****************************************************************
    // drivers
    // ****************************************************************
    task automatic apb(input logic w, input logic [11:0] a, input lsi_word_t d, input logic er, input lsi_word_t ex);
        int k;
        expQ.push_back(lsi_exp_s'{~w, er, ex});
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input lsi_word_t d);
        apb(1'b1, a, d, 1'b0, 32'h0000_0000);
    endtask : wr

    task automatic rd(input logic [11:0] a, input lsi_word_t ex);
        apb(1'b0, a, 32'h0000_0000, 1'b0, ex);
    endtask : rd

    task automatic ev(input logic [6:0] v);
        @(posedge sys_clk);
        netEvents <= v;
        @(posedge sys_clk);
    endtask : ev

    task automatic pin_chk(input logic exp);
        pinQ.push_back(exp);
        @(posedge sys_clk);
        pinReq <= 1'b1;
        @(posedge sys_clk);
        pinReq <= 1'b0;
    endtask : pin_chk

    // ****************************************************************
    // monitors
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (psel && penable && pready) begin
            curE = expQ.pop_front();
            cmp_word({31'h0000_0000, pslverr}, {31'h0000_0000, curE.err});
            if (curE.isRd) begin
                cmp_word(prdata, curE.data);
            end
        end
    end

    always @(negedge sys_clk) begin
        if (pinReq) begin
            cmp_pin(padLevel, pinQ.pop_front());
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        netEvents = '0;
        pinReq = 1'b0;
        seed = 32'd78394;
        errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`LSI_OFS_CTRL, 32'h0000_0080);
        rd(`LSI_OFS_PROGEN, 32'h0000_0000);
        pin_chk(1'b1);
        wr(`LSI_OFS_CTRL, 32'h0000_4070);
        rd(`LSI_OFS_CTRL, 32'h0000_0080);
        wr(`LSI_OFS_PROGEN, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0000_0000, 1'b1, 32'h0000_0000);
        wr(`LSI_OFS_CTRL, 32'hFFFF_BFFF);
        rd(`LSI_OFS_CTRL, 32'h0000_33F0);
        for (i = 0; i < 6; i++) begin
            cv = 32'h0000_4000 | (32'h0000_0001 << bitTab[i]);
            wr(`LSI_OFS_CTRL, cv);
            ev(onTab[i]);
            rd(`LSI_OFS_CTRL, cv | 32'h0000_8000);
            pin_chk(1'b1);
            ev(offTab[i]);
            rd(`LSI_OFS_CTRL, cv);
            pin_chk(1'b0);
        end
        wr(`LSI_OFS_CTRL, 32'h0000_0030);
        ev(7'h02);
        rd(`LSI_OFS_CTRL, 32'h0000_8030);
        pin_chk(1'b0);
        ev(7'h00);
        pin_chk(1'b1);
        wr(`LSI_OFS_CTRL, 32'h0000_2040);
        ev(7'h08);
        rd(`LSI_OFS_CTRL, 32'h0000_A040);
        pin_chk(1'b1);
        wr(`LSI_OFS_CTRL, 32'h0000_4090);
        ev(7'h01);
        ev(7'h00);
        pin_chk(1'b1);
        rd(`LSI_OFS_CTRL, 32'h0000_4090);
        repeat (SC + 8) @(posedge sys_clk);
        pin_chk(1'b0);
        ev(7'h01);
        ev(7'h00);
        wr(`LSI_OFS_CTRL, 32'h0000_4010);
        pin_chk(1'b0);
        repeat (8) begin
            cv = xs() & 32'h0000_5370;
            evr = 7'(xs());
            wr(`LSI_OFS_CTRL, cv);
            ev(evr);
            rd(`LSI_OFS_CTRL, cv | {16'h0000, comb(cv, evr), 15'h0000});
            pin_chk(cv[14] ? comb(cv, evr) : ~comb(cv, evr));
        end
        fork
            rd(`LSI_OFS_CTRL, cv | {16'h0000, comb(cv, evr), 15'h0000});
            begin
                @(posedge sys_clk);
                clkEn <= 1'b0;
                repeat (3) @(posedge sys_clk);
                clkEn <= 1'b1;
            end
        join
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`LSI_OFS_CTRL, 32'h0000_0080);
        rd(`LSI_OFS_PROGEN, 32'h0000_0000);
        pin_chk(1'b1);
        repeat (3) @(posedge sys_clk);
        tally_and_finish();
    end
endmodule : lsi_top_test
